// file: hdl/dtcm_top.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: 32-bit mode joins halves; A mode decides
// R02: count down, reload joined load after zero
// R03: one-shot clears enable, periodic keeps running
// R04: zero sets timeout flag until cleared
// R05: ADC trigger pulses only when enabled
// R06: load write takes effect next clock
// R07: debug stall freezes count during halt
// R08: real-time counts up, first loads one
// R09: even pin reference divided to 1 Hz
// R10: match rolls count to zero, continues
// R11: real-time match flag, cleared by clear bit
// R12: stall override keeps real-time running
// R13: config four gives two independent timers
// R14: 16-bit down counter with 8-bit prescaler
// R15: 16-bit zero reloads load and prescale
// R16: prescale N gives N+1 clocks per count
// R17: edge count on selected edges, no prescaler
// R18: source holds level two clocks per edge
// R19: each edge decrements; match sets flag
// R20: after match reload, disable, ignore edges
// R21: load minus match equals edge count
// R22: config zero 32-bit, one real-time
// R23: mode one is one-shot, two periodic
// R24: capture bit zero, mode three: edge count
// R25: reset: idle, counters and loads all ones
// R26: interrupt high while any masked flag set
module dtcm_top
   import dtcm_pkg::*;
#(
   parameter int RTC_DIV = RTC_DIV_DEF
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // configuration levels
   input wire logic [2:0] WIDTH_CFG,
   input wire logic [1:0] A_MODE,
   input wire logic A_CAP_MODE,
   input wire logic [1:0] B_MODE,
   input wire logic B_CAP_MODE,
   input wire logic [1:0] A_EVENT,
   input wire logic [1:0] B_EVENT,
   input wire logic A_ADC_TRIG_EN,
   input wire logic B_ADC_TRIG_EN,
   input wire logic A_DEBUG_STALL,
   input wire logic B_DEBUG_STALL,
   input wire logic RTC_STALL_OVR,
   input wire logic [15:0] A_MATCH,
   input wire logic [15:0] B_MATCH,
   input wire logic [4:0] IRQ_MASK,
   // enable strobes
   input wire logic A_ENABLE_SET,
   input wire logic A_ENABLE_CLR,
   input wire logic B_ENABLE_SET,
   input wire logic B_ENABLE_CLR,
   // load and prescale write strobes
   input wire logic A_LOAD_WR,
   input wire logic [15:0] A_LOAD_DATA,
   input wire logic B_LOAD_WR,
   input wire logic [15:0] B_LOAD_DATA,
   input wire logic A_PRESC_WR,
   input wire logic [7:0] A_PRESC_DATA,
   input wire logic B_PRESC_WR,
   input wire logic [7:0] B_PRESC_DATA,
   // flag clear strobes
   input wire logic [4:0] IRQ_CLEAR,
   // debug and capture pins
   input wire logic CPU_HALT,
   input wire logic CCP_EVEN,
   input wire logic CCP_ODD,
   // status outputs
   output logic A_ENABLE,
   output logic B_ENABLE,
   output logic [15:0] A_COUNT,
   output logic [15:0] B_COUNT,
   output logic [4:0] RAW_STATUS,
   output logic [4:0] MASKED_STATUS,
   output logic IRQ,
   output logic ADC_TRIG_A,
   output logic ADC_TRIG_B
);
   dtcm_op_t op;
   logic [15:0] cnt_r [2], cnt_nxt [2], load_r [2], load_wdata [2], match [2];
   logic [7:0] presc_r [2];
   logic [1:0] en_r, hw_clr, to_ev, match_ev, presc_run, presc_reload, presc_tick;
   logic [1:0] edge_ev, stall, load_wr, cap_mode, en_set, en_clr, trig_r;
   logic [1:0] mode [2];
   logic [31:0] cnt32, load32, match32;
   logic [4:0] raw_r, raw_nxt, masked_r;
   logic [15:0] div_r;
   logic rtc_ev, stall_rtc, rtc_seen_r, rtc_first, ref_edge, rtc_tick, irq_r;

   // gather per-timer inputs so one loop serves both halves
   assign load_wr = {B_LOAD_WR, A_LOAD_WR};
   assign load_wdata[0] = A_LOAD_DATA;
   assign load_wdata[1] = B_LOAD_DATA;
   assign mode[0] = A_MODE;
   assign mode[1] = B_MODE;
   assign cap_mode = {B_CAP_MODE, A_CAP_MODE};
   assign en_set = {B_ENABLE_SET, A_ENABLE_SET};
   assign en_clr = {B_ENABLE_CLR, A_ENABLE_CLR};
   assign match[0] = A_MATCH;
   assign match[1] = B_MATCH;
   assign cnt32 = {cnt_r[1], cnt_r[0]};
   assign load32 = {load_r[1], load_r[0]};
   assign match32 = {match[1], match[0]}; // joined match, A in low half

   // width decode; unlisted codes leave the module idle
   always_comb begin
      unique case (WIDTH_CFG)
         CFG_JOIN32: op = OP_JOIN32; // [R22]
         CFG_RTC: op = OP_RTC; // [R22]
         CFG_SPLIT16: op = OP_SPLIT16; // [R13]
         default: op = OP_IDLE;
      endcase
   end

   // halt freezes a timer only if its stall bit is set
   assign stall = {CPU_HALT & B_DEBUG_STALL, CPU_HALT & A_DEBUG_STALL}; // [R07]
   assign stall_rtc = CPU_HALT & (A_DEBUG_STALL | B_DEBUG_STALL) & ~RTC_STALL_OVR; // [R12]

   // edge detectors on the capture pins
   dtcm_edge u_edge_a (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin(CCP_EVEN),
      .sel(A_EVENT),
      .edge_pulse(edge_ev[0])
   );
   dtcm_edge u_edge_b (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin(CCP_ODD),
      .sel(B_EVENT),
      .edge_pulse(edge_ev[1])
   );
   // the reference clock is sampled, not used as a clock, so it needs no crossing
   dtcm_edge u_edge_ref (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pin(CCP_EVEN),
      .sel(EV_RISE),
      .edge_pulse(ref_edge)
   );

   // prescalers, used only by 16-bit one-shot and periodic timers
   dtcm_presc u_presc_a (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .run(presc_run[0]),
      .reload(presc_reload[0]),
      .value(presc_r[0]),
      .tick(presc_tick[0])
   );
   dtcm_presc u_presc_b (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .run(presc_run[1]),
      .reload(presc_reload[1]),
      .value(presc_r[1]),
      .tick(presc_tick[1])
   );

   // reference divider: one tick per RTC_DIV reference edges
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         div_r <= 16'h0000;
      end else if (op != OP_RTC || !en_r[0]) begin
         div_r <= 16'h0000;
      end else if (ref_edge && !stall_rtc) begin
         div_r <= rtc_tick ? 16'h0000 : div_r + 16'h0001; // [R09]
      end
   end
   assign rtc_tick = ref_edge & ~stall_rtc & (div_r == 16'(RTC_DIV - 1));

   // the real-time start value is forced once only, on first selection
   assign rtc_first = (op == OP_RTC) & ~rtc_seen_r; // [R08]
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rtc_seen_r <= 1'b0;
      end else if (op == OP_RTC) begin
         rtc_seen_r <= 1'b1;
      end
   end

   // next count and events for every mode
   always_comb begin
      cnt_nxt = cnt_r;
      hw_clr = 2'b00;
      to_ev = 2'b00;
      match_ev = 2'b00;
      rtc_ev = 1'b0;
      presc_run = 2'b00;
      presc_reload = 2'b00;
      unique case (op)
         OP_JOIN32: begin
            // timer B mode is ignored here [R01]
            if (en_r[0] && !stall[0]) begin
               if (cnt32 == ZERO32) begin
                  {cnt_nxt[1], cnt_nxt[0]} = load32; // [R02]
                  to_ev[0] = 1'b1; // [R04]
                  hw_clr[0] = (mode[0] == MODE_ONESHOT); // [R03] [R23]
               end else begin
                  {cnt_nxt[1], cnt_nxt[0]} = cnt32 - 32'h00000001; // [R01] [R02]
               end
            end
         end
         OP_RTC: begin
            if (rtc_first) begin
               {cnt_nxt[1], cnt_nxt[0]} = RTC_FIRST; // [R08]
            end else if (en_r[0] && rtc_tick) begin
               if (cnt32 == match32) begin
                  {cnt_nxt[1], cnt_nxt[0]} = ZERO32; // [R10]
                  rtc_ev = 1'b1; // [R11]
               end else begin
                  {cnt_nxt[1], cnt_nxt[0]} = cnt32 + 32'h00000001; // [R08]
               end
            end
         end
         OP_SPLIT16: begin
            for (int i = 0; i < 2; i++) begin
               if (mode[i] == MODE_ONESHOT || mode[i] == MODE_PERIODIC) begin
                  presc_run[i] = en_r[i] & ~stall[i]; // [R14] [R07]
                  presc_reload[i] = load_wr[i];
                  if (presc_tick[i]) begin // [R16]
                     if (cnt_r[i] == 16'h0000) begin
                        cnt_nxt[i] = load_r[i]; // [R15]
                        presc_reload[i] = 1'b1; // [R15]
                        to_ev[i] = 1'b1; // [R04]
                        hw_clr[i] = (mode[i] == MODE_ONESHOT); // [R03]
                     end else begin
                        cnt_nxt[i] = cnt_r[i] - 16'h0001; // [R14]
                     end
                  end
               end else if (mode[i] == MODE_EDGE && !cap_mode[i]) begin // [R24]
                  // no prescaler here; edges step the count directly [R17]
                  if (en_r[i] && edge_ev[i] && !stall[i]) begin
                     cnt_nxt[i] = cnt_r[i] - 16'h0001; // [R19]
                     if (cnt_nxt[i] == match[i]) begin // [R21]
                        cnt_nxt[i] = load_r[i]; // [R20]
                        match_ev[i] = 1'b1; // [R19]
                        hw_clr[i] = 1'b1; // [R20]
                     end
                  end
               end
            end
         end
         OP_IDLE: cnt_nxt = cnt_r; // an idle module holds its count
      endcase
   end

   // counters; a load write overrides counting, except in real-time mode
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         cnt_r[0] <= CNT_RST; // [R25]
         cnt_r[1] <= CNT_RST; // [R25]
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (load_wr[i] && op != OP_RTC) begin
               cnt_r[i] <= load_wdata[i]; // [R06]
            end else begin
               cnt_r[i] <= cnt_nxt[i];
            end
         end
      end
   end

   // interval load and prescale registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         load_r[0] <= LOAD_RST; // [R25]
         load_r[1] <= LOAD_RST; // [R25]
         presc_r[0] <= PRESC_RST; // [R25]
         presc_r[1] <= PRESC_RST; // [R25]
      end else begin
         if (A_LOAD_WR) load_r[0] <= A_LOAD_DATA;
         if (B_LOAD_WR) load_r[1] <= B_LOAD_DATA;
         if (A_PRESC_WR) presc_r[0] <= A_PRESC_DATA;
         if (B_PRESC_WR) presc_r[1] <= B_PRESC_DATA;
      end
   end

   // enables: a software set in the same cycle as a hardware stop wins
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         en_r <= 2'b00; // [R25]
      end else begin
         en_r <= en_set | (en_r & ~en_clr & ~hw_clr); // [R03] [R20]
      end
   end

   // sticky flags: a new event beats a clear in the same cycle
   always_comb begin
      raw_nxt = raw_r & ~IRQ_CLEAR; // [R11]
      raw_nxt[FL_A_TO] = raw_nxt[FL_A_TO] | to_ev[0]; // [R04]
      raw_nxt[FL_B_TO] = raw_nxt[FL_B_TO] | to_ev[1]; // [R04]
      raw_nxt[FL_A_MATCH] = raw_nxt[FL_A_MATCH] | match_ev[0]; // [R19]
      raw_nxt[FL_B_MATCH] = raw_nxt[FL_B_MATCH] | match_ev[1]; // [R19]
      raw_nxt[FL_RTC] = raw_nxt[FL_RTC] | rtc_ev; // [R11]
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         raw_r <= 5'h00;
         masked_r <= 5'h00;
         irq_r <= 1'b0;
      end else begin
         raw_r <= raw_nxt;
         masked_r <= raw_nxt & IRQ_MASK; // [R04] [R11]
         irq_r <= |(raw_nxt & IRQ_MASK); // [R26]
      end
   end

   // ADC trigger pulses, one clock per time-out
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         trig_r <= 2'b00;
      end else begin
         trig_r <= to_ev & {B_ADC_TRIG_EN, A_ADC_TRIG_EN}; // [R05]
      end
   end

   assign {B_ENABLE, A_ENABLE} = en_r;
   assign A_COUNT = cnt_r[0];
   assign B_COUNT = cnt_r[1];
   assign RAW_STATUS = raw_r;
   assign MASKED_STATUS = masked_r;
   assign IRQ = irq_r;
   assign {ADC_TRIG_B, ADC_TRIG_A} = trig_r;

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence s_join_zero;
      op == OP_JOIN32 && en_r[0] && !stall[0] && cnt32 == ZERO32 && load_wr == 2'b00;
   endsequence
   sequence s_edge_done;
      match_ev[0] && !A_ENABLE_SET && !A_LOAD_WR;
   endsequence

   a_join_reload: assert property (s_join_zero |=> cnt32 == $past(load32)) // [R02]
      else $error("joined counter did not reload after zero");
   a_oneshot_stop: assert property ( // [R03]
      (s_join_zero and (mode[0] == MODE_ONESHOT && !A_ENABLE_SET)) |=> !en_r[0])
      else $error("one-shot timer still enabled after time-out");
   a_timeout_flag: assert property ( // [R04]
      s_join_zero ##1 !IRQ_CLEAR[FL_A_TO] |-> raw_r[FL_A_TO] ##1 raw_r[FL_A_TO])
      else $error("time-out flag not set or not held");
   a_adc_gate: assert property (ADC_TRIG_A |-> $past(to_ev[0]) && $past(A_ADC_TRIG_EN)) // [R05]
      else $error("trigger pulse without enabled time-out");
   a_load_follow: assert property ( // [R06]
      A_LOAD_WR && op != OP_RTC |=> A_COUNT == $past(A_LOAD_DATA))
      else $error("counter did not take new load value");
   a_debug_freeze: assert property ( // [R07]
      op == OP_JOIN32 && stall[0] && load_wr == 2'b00 && $stable(WIDTH_CFG) |=> $stable(cnt32))
      else $error("counter moved during debug halt");
   a_rtc_first: assert property ( // [R08]
      op == OP_RTC && !rtc_seen_r && load_wr == 2'b00 |=> cnt32 == RTC_FIRST)
      else $error("real-time counter not started at one");
   a_rtc_roll: assert property (rtc_ev |=> cnt32 == ZERO32 && raw_r[FL_RTC]) // [R10]
      else $error("real-time match did not roll over and flag");
   a_edge_finish: assert property ( // [R20]
      s_edge_done |=> !en_r[0] && raw_r[FL_A_MATCH] && A_COUNT == $past(load_r[0]))
      else $error("edge count completion wrong");
   a_irq_level: assert property (IRQ == (|MASKED_STATUS)) // [R26]
      else $error("interrupt does not follow masked flags");
endmodule
`default_nettype wire

// file: hdl/dtcm_pkg.sv
package dtcm_pkg;
   // width configuration codes
   localparam logic [2:0] CFG_JOIN32 = 3'h0;
   localparam logic [2:0] CFG_RTC = 3'h1;
   localparam logic [2:0] CFG_SPLIT16 = 3'h4;
   // per-timer mode field codes
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;
   localparam logic [1:0] MODE_EDGE = 2'h3;
   // edge event select codes
   localparam logic [1:0] EV_RISE = 2'h0;
   localparam logic [1:0] EV_FALL = 2'h1;
   localparam logic [1:0] EV_BOTH = 2'h3;
   // reset and load values
   localparam logic [15:0] LOAD_RST = 16'hFFFF;
   localparam logic [15:0] CNT_RST = 16'hFFFF;
   localparam logic [7:0] PRESC_RST = 8'h00;
   localparam logic [31:0] RTC_FIRST = 32'h00000001;
   localparam logic [31:0] ZERO32 = 32'h00000000;
   // real-time reference division
   localparam int RTC_REF_HZ = 32768;
   localparam int RTC_TICK_HZ = 1;
   localparam int RTC_DIV_DEF = RTC_REF_HZ / RTC_TICK_HZ;
   // status flag bit positions
   localparam int NFLAG = 5;
   localparam int FL_A_TO = 0;
   localparam int FL_A_MATCH = 1;
   localparam int FL_RTC = 2;
   localparam int FL_B_TO = 3;
   localparam int FL_B_MATCH = 4;
   // decoded operating width
   typedef enum logic [1:0] {OP_IDLE, OP_JOIN32, OP_RTC, OP_SPLIT16} dtcm_op_t;
endpackage

// file: hdl/dtcm_edge.sv
`timescale 1ns/1ps
`default_nettype none
module dtcm_edge
   import dtcm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin and selection
   input wire logic pin,
   input wire logic [1:0] sel,
   // one-cycle event
   output logic edge_pulse
);
   logic prev_r;
   logic primed_r;
   logic rise;
   logic fall;

   // the first sampled level is not an edge, so a pin high at reset is not counted
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         primed_r <= 1'b0;
      end else begin
         prev_r <= pin;
         primed_r <= 1'b1;
      end
   end

   assign rise = primed_r & pin & ~prev_r;
   assign fall = primed_r & ~pin & prev_r;

   // select which transitions count
   always_comb begin
      unique case (sel)
         EV_RISE: edge_pulse = rise;
         EV_FALL: edge_pulse = fall;
         EV_BOTH: edge_pulse = rise | fall;
         default: edge_pulse = 1'b0; // code 2 is not a valid selection
      endcase
   end
endmodule
`default_nettype wire

// file: hdl/dtcm_presc.sv
`timescale 1ns/1ps
`default_nettype none
module dtcm_presc
   import dtcm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic reload,
   input wire logic [7:0] value,
   // one count step
   output logic tick
);
   logic [7:0] cnt_r;

   // tick every value+1 clocks while running
   assign tick = run & (cnt_r == 8'h00);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= PRESC_RST;
      end else if (reload) begin
         cnt_r <= value;
      end else if (run) begin
         cnt_r <= tick ? value : cnt_r - 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: tb/dtcm_src.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the capture pins: edge source and slow real-time reference
module dtcm_src #(
   parameter int HALF_CYC = 763
)
(
   // clock
   input wire logic clk,
   // pins toward the timer
   output logic pin_even,
   output logic pin_odd
);
   // pins rest low until a scenario moves them
   initial begin
      pin_even = 1'b0;
      pin_odd = 1'b0;
   end
   // each new level is held four clocks, two more than the detector needs
   task automatic toggle(input bit odd, input int n);
      repeat (n) begin
         @(posedge clk);
         if (odd) begin
            pin_odd <= ~pin_odd;
         end else begin
            pin_even <= ~pin_even;
         end
         repeat (3) @(posedge clk);
      end
   endtask
   // 32.768 kHz square wave, counted in system clocks to stay edge aligned
   task automatic ref_run(input int periods);
      repeat (2 * periods) begin
         @(posedge clk);
         pin_even <= ~pin_even;
         repeat (HALF_CYC - 1) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/dual_timer_counter_modes_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_modes_test;
   import dtcm_pkg::*;
   // a short real-time divider keeps the run brief
   localparam int DIV = 4;
   localparam int LA = 0, LB = 1, PA = 2, PB = 3, ESA = 4, ECA = 5, ESB = 6, ECB = 7, CLR = 8;
   logic CLK_SYS, RST_N;
   logic [2:0] WIDTH_CFG;
   logic [1:0] A_MODE, B_MODE, A_EVENT, B_EVENT, ev;
   logic [4:0] IRQ_MASK, IRQ_CLEAR, RAW_STATUS, MASKED_STATUS, f;
   logic [15:0] A_MATCH, B_MATCH, A_LOAD_DATA, B_LOAD_DATA, A_COUNT, B_COUNT, v;
   logic [7:0] A_PRESC_DATA, B_PRESC_DATA;
   logic A_CAP_MODE, B_CAP_MODE, A_ADC_TRIG_EN, B_ADC_TRIG_EN, A_DEBUG_STALL, B_DEBUG_STALL;
   logic RTC_STALL_OVR, A_ENABLE_SET, A_ENABLE_CLR, B_ENABLE_SET, B_ENABLE_CLR, CPU_HALT;
   logic A_LOAD_WR, B_LOAD_WR, A_PRESC_WR, B_PRESC_WR;
   logic A_ENABLE, B_ENABLE, IRQ, ADC_TRIG_A, ADC_TRIG_B;
   wire logic CCP_EVEN;
   wire logic CCP_ODD;
   int mismatches = 0;
   int num_checks = 0;
   int n;
   bit t;

   dtcm_top #(.RTC_DIV(DIV)) u_dut (
      .CLK_SYS, .RST_N, .WIDTH_CFG, .A_MODE, .A_CAP_MODE, .B_MODE, .B_CAP_MODE,
      .A_EVENT, .B_EVENT, .A_ADC_TRIG_EN, .B_ADC_TRIG_EN, .A_DEBUG_STALL, .B_DEBUG_STALL,
      .RTC_STALL_OVR, .A_MATCH, .B_MATCH, .IRQ_MASK, .A_ENABLE_SET, .A_ENABLE_CLR,
      .B_ENABLE_SET, .B_ENABLE_CLR, .A_LOAD_WR, .A_LOAD_DATA, .B_LOAD_WR, .B_LOAD_DATA,
      .A_PRESC_WR, .A_PRESC_DATA, .B_PRESC_WR, .B_PRESC_DATA, .IRQ_CLEAR, .CPU_HALT,
      .CCP_EVEN, .CCP_ODD, .A_ENABLE, .B_ENABLE, .A_COUNT, .B_COUNT, .RAW_STATUS,
      .MASKED_STATUS, .IRQ, .ADC_TRIG_A, .ADC_TRIG_B
   );

   dtcm_src #(.HALF_CYC(763)) u_src (.clk(CLK_SYS), .pin_even(CCP_EVEN), .pin_odd(CCP_ODD));

   // 50 MHz system clock
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   task automatic nx(input int k);
      repeat (k) @(posedge CLK_SYS);
   endtask

   // case equality so an unknown never counts as a match
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // one strobe raised at an edge, taken at the next, dropped there
   task automatic wr(input int k, input logic [15:0] d);
      @(posedge CLK_SYS);
      A_LOAD_DATA <= d;
      B_LOAD_DATA <= d;
      A_PRESC_DATA <= d[7:0];
      B_PRESC_DATA <= d[7:0];
      case (k)
         LA: A_LOAD_WR <= 1'b1;
         LB: B_LOAD_WR <= 1'b1;
         PA: A_PRESC_WR <= 1'b1;
         PB: B_PRESC_WR <= 1'b1;
         ESA: A_ENABLE_SET <= 1'b1;
         ECA: A_ENABLE_CLR <= 1'b1;
         ESB: B_ENABLE_SET <= 1'b1;
         ECB: B_ENABLE_CLR <= 1'b1;
         default: IRQ_CLEAR <= d[4:0];
      endcase
      @(posedge CLK_SYS);
      {A_LOAD_WR, B_LOAD_WR, A_PRESC_WR, B_PRESC_WR} <= '0;
      {A_ENABLE_SET, A_ENABLE_CLR, B_ENABLE_SET, B_ENABLE_CLR} <= '0;
      IRQ_CLEAR <= '0;
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // a hung wait would otherwise run forever; the whole run needs about 18.5k cycles
   initial begin
      repeat (40000) @(posedge CLK_SYS);
      mismatches++;
      conclude();
   end

   // main sequence
   initial begin
      RST_N = 1'b0;
      {WIDTH_CFG, A_MODE, B_MODE, A_EVENT, B_EVENT, IRQ_MASK, IRQ_CLEAR} = '0;
      {A_MATCH, B_MATCH, A_LOAD_DATA, B_LOAD_DATA, A_PRESC_DATA, B_PRESC_DATA} = '0;
      {A_CAP_MODE, B_CAP_MODE, A_ADC_TRIG_EN, B_ADC_TRIG_EN, A_DEBUG_STALL} = '0;
      {B_DEBUG_STALL, RTC_STALL_OVR, A_ENABLE_SET, A_ENABLE_CLR, B_ENABLE_SET} = '0;
      {B_ENABLE_CLR, CPU_HALT, A_LOAD_WR, B_LOAD_WR, A_PRESC_WR, B_PRESC_WR} = '0;
      nx(5);
      RST_N <= 1'b1;
      #1 chk({B_COUNT, A_COUNT}, 32'hFFFFFFFF);
      chk({A_ENABLE, B_ENABLE, RAW_STATUS, MASKED_STATUS, IRQ, ADC_TRIG_A}, 0);
      // joined one-shot; timer B mode set to periodic must not matter
      nx(1);
      WIDTH_CFG <= CFG_JOIN32;
      A_MODE <= MODE_ONESHOT;
      B_MODE <= MODE_PERIODIC;
      A_ADC_TRIG_EN <= 1'b1;
      IRQ_MASK <= 5'h01;
      wr(LA, 16'h0003);
      wr(LB, 16'h0000);
      wr(ESA, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         #1 chk({B_COUNT, A_COUNT}, (i < 4) ? 3 - i : 3);
         chk(A_ENABLE, i < 4);
         chk(ADC_TRIG_A, i == 4);
         chk({RAW_STATUS[0], MASKED_STATUS[0], IRQ}, (i == 4) ? 7 : 0);
         if (i < 4) nx(1);
      end
      nx(1);
      #1 chk({ADC_TRIG_A, RAW_STATUS[0], IRQ}, 3'h3);
      wr(CLR, 16'h0001);
      #1 chk({RAW_STATUS, MASKED_STATUS, IRQ}, 0);
      // periodic with a load rewrite in flight and a debug halt
      nx(1);
      A_MODE <= MODE_PERIODIC;
      A_ADC_TRIG_EN <= 1'b0;
      A_DEBUG_STALL <= 1'b1;
      wr(LA, 16'h0005);
      wr(ESA, 16'h0000);
      nx(2);
      wr(LA, 16'h0009);
      #1 chk(A_COUNT, 16'h0009);
      nx(1);
      CPU_HALT <= 1'b1;
      nx(1);
      #1 v = A_COUNT;
      nx(4);
      #1 chk(A_COUNT, v);
      nx(1);
      CPU_HALT <= 1'b0;
      for (int i = 0; i < 20 && RAW_STATUS[0] !== 1'b1; i++) begin
         nx(1);
         #1 chk(ADC_TRIG_A, 0);
      end
      chk({A_ENABLE, RAW_STATUS[0], B_COUNT, A_COUNT}, {2'b11, 32'h00000009});
      wr(ECA, 16'h0000);
      wr(CLR, 16'h001F);
      // split: B one-shot without prescale, A periodic with prescale two
      nx(1);
      WIDTH_CFG <= CFG_SPLIT16;
      B_MODE <= MODE_ONESHOT;
      B_ADC_TRIG_EN <= 1'b1;
      wr(PA, 16'h0002);
      wr(LA, 16'h0002);
      wr(LB, 16'h0001);
      wr(ESB, 16'h0000);
      #1 chk(B_COUNT, 16'h0001);
      nx(2);
      #1 chk({B_ENABLE, RAW_STATUS[3], B_COUNT}, {2'b01, 16'h0001});
      chk(ADC_TRIG_B, 1);
      wr(ESA, 16'h0000);
      #1 for (int k = 0; k < 4; k++) begin
         v = A_COUNT;
         n = 0;
         do begin
            nx(1);
            #1 n++;
         end while (A_COUNT === v && n < 9);
         if (k > 0) chk(n, 3);
         chk(A_COUNT, (4 - k) % 3);
      end
      wr(ECA, 16'h0000);
      wr(CLR, 16'h001F);
      // edge counting on each event code, three edges between load and match
      nx(1);
      A_MODE <= MODE_EDGE;
      B_MODE <= MODE_EDGE;
      A_MATCH <= 16'h0007;
      B_MATCH <= 16'h0007;
      IRQ_MASK <= 5'h1F;
      wr(LA, 16'h000A);
      wr(LB, 16'h000A);
      for (int i = 0; i < 3; i++) begin
         ev = (i == 0) ? EV_RISE : (i == 1) ? EV_FALL : EV_BOTH;
         t = (i == 1);
         f = t ? 5'h10 : 5'h02;
         nx(1);
         A_EVENT <= ev;
         B_EVENT <= ev;
         wr(t ? ESB : ESA, 16'h0000);
         u_src.toggle(t, 2);
         #1 chk(t ? B_COUNT : A_COUNT, (i == 2) ? 8 : 9);
         u_src.toggle(t, 4);
         #1 chk(t ? B_COUNT : A_COUNT, 16'h000A);
         chk(t ? B_ENABLE : A_ENABLE, 0);
         chk({RAW_STATUS, MASKED_STATUS, IRQ}, {f, f, 1'b1});
         wr(CLR, 16'h001F);
      end
      // event code two selects no edge, so the count must stay put
      A_EVENT <= 2'h2;
      wr(ESA, 16'h0000);
      u_src.toggle(0, 2);
      #1 chk(A_COUNT, 16'h000A);
      wr(ECA, 16'h0000);
      // real-time count held running through a halt by the override
      nx(1);
      WIDTH_CFG <= CFG_RTC;
      A_MATCH <= 16'h0003;
      B_MATCH <= 16'h0000;
      RTC_STALL_OVR <= 1'b1;
      B_DEBUG_STALL <= 1'b1;
      CPU_HALT <= 1'b1;
      nx(1);
      #1 chk({B_COUNT, A_COUNT}, 32'h00000001);
      wr(ESA, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         u_src.ref_run(DIV);
         #1 chk({B_COUNT, A_COUNT}, (k + 2) % 4);
      end
      chk({RAW_STATUS[2], MASKED_STATUS[2], IRQ, A_ENABLE}, 4'hF);
      wr(CLR, 16'h0004);
      #1 chk({RAW_STATUS, MASKED_STATUS, IRQ}, 0);
      conclude();
   end
endmodule
`default_nettype wire
